// ---- hdl/adcseq_div_if.sv ----
// Interface carrying the converter clock enable between divider and sequencer.
`timescale 1ns/1ps
interface adcseq_div_if;
  logic [2:0] sel;
  logic run;
  logic tick;
  modport div (input sel, input run, output tick);
  modport seq (output sel, output run, input tick);
endinterface

// ---- hdl/adcseq_divider.sv ----
// Converter clock divider producing a one-cycle enable every two to the select power cycles.
`timescale 1ns/1ps
module adcseq_divider
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Divider link.
  adcseq_div_if.div bus
);
  import adcseq_pkg::*;

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic [6:0] limit;

  assign bus.tick = tick_q;

  always_comb
  begin
    limit = 7'((8'h01 << bus.sel) - 8'h01);
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!bus.run)
    begin
      cnt_d = 7'h00;
    end
    else if (cnt_q >= limit)
    begin
      cnt_d = 7'h00;
      tick_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + 7'h01;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule

// ---- hdl/adcseq_pkg.sv ----
// Package with register map, field positions and timing constants of the converter sequencer.
package adcseq_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL_FIRST = 8'h00;
  localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h08;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_BANDGAP = 8'h10;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h14;
  localparam logic [7:0] ADDR_SAMPLE = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int F1_CHAN_LSB = 0;
  localparam int F1_RFS = 4;
  localparam int F1_PWR = 5;
  localparam int F1_BUSY = 6;
  localparam int F1_START = 7;
  localparam int F2_CLK_LSB = 0;
  localparam int F2_REF_LSB = 3;
  localparam int F2_SRC_LSB = 5;
  localparam int FI_GIE = 0;
  localparam int FI_CIE = 1;
  localparam int FI_FLAG = 2;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [11:0] FULL_SCALE = 12'hFFF;

  // ****************************************
  // Timing counts in converter clock cycles
  // ****************************************
  localparam logic [4:0] SAMPLE_CYCLES = 5'h04;
  localparam logic [4:0] CONVERT_CYCLES = 5'h0C;
  localparam logic [4:0] TOTAL_CYCLES = SAMPLE_CYCLES + CONVERT_CYCLES;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_SAMPLE, ST_CONVERT} adcseq_state_type;

endpackage

// ---- hdl/adcseq_top.sv ----
// Converter sequencer top with AXI4-Lite register slave.
//
// Contract
// - Bandgap output driven when enable set, else released.
// - Bandgap register upper seven bits read zero.
// - Sample four, convert twelve, sixteen cycles total.
// - Conversion runs in hardware, bus never stalls.
// - Result bytes arranged by format select bit.
// - Busy high during conversion, result valid after.
// - Converter powered down when power enable clear.
// - Twelve-bit result, full scale FFF hex.
// - Reference code 01 selects supply, else pin.
// - Source 000 or 101-111 selects external pin.
// - Converter clock is system clock over two-power.
`timescale 1ns/1ps
module adcseq_top
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // AXI4-Lite write channels.
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Analog front end.
  input wire logic [11:0] i_sar_code,
  output logic o_sar_power,
  output logic o_sar_reset,
  output logic o_sar_sample,
  output logic o_sar_ref_supply,
  output logic o_sar_ext_pin,
  output logic [2:0] o_sar_int_source,
  output logic [3:0] o_sar_channel,
  output logic o_bandgap_out,
  output logic o_bandgap_oe,
  // Interrupt request.
  output logic o_irq
);
  import adcseq_pkg::*;

  // ****************************************
  // State
  // ****************************************
  adcseq_div_if div_link ();
  adcseq_state_type st_q, st_d;
  logic [7:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d, intc_q, intc_d, bg_q, bg_d;
  logic [11:0] res_q, res_d;
  logic [4:0] cyc_q, cyc_d;
  logic start_q;
  logic done_d;
  logic awdone_q, awdone_d, wdone_q, wdone_d, bvalid_q, bvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bresp_err_q, bresp_err_d;
  logic rvalid_q, rvalid_d, rresp_err_q, rresp_err_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] src;
  logic wr_fire, rd_fire, start_new;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic [7:0] sample_out;
  logic [15:0] res_fmt;

  function automatic logic [15:0] fmt_result(input logic [11:0] r, input logic rfs);
    fmt_result = rfs ? {4'h0, r} : {r, 4'h0};
  endfunction

  function automatic logic map_ok(input logic [7:0] a);
    map_ok = (a == ADDR_CTRL_FIRST) || (a == ADDR_CTRL_SECOND) || (a == ADDR_RESULT_LOW)
      || (a == ADDR_RESULT_HIGH) || (a == ADDR_BANDGAP) || (a == ADDR_INT_CTRL)
      || (a == ADDR_SAMPLE);
  endfunction

  adcseq_divider u_div
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .bus(div_link)
  );

  assign src = ctl2_q[F2_SRC_LSB +: 3];
  assign div_link.sel = ctl2_q[F2_CLK_LSB +: 3];
  assign div_link.run = (st_q == ST_SAMPLE) || (st_q == ST_CONVERT);
  assign start_new = ctl1_q[F1_START];
  assign sample_out = {4'h0, ctl1_q[F1_PWR], 3'h0};
  assign res_fmt = fmt_result(res_q, ctl1_q[F1_RFS]);

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign wr_fire = awdone_q && wdone_q && !bvalid_q;
  assign rd_fire = i_arvalid && !rvalid_q;

  always_comb
  begin
    rd_ok = map_ok(i_araddr);
    unique case (i_araddr)
      ADDR_CTRL_FIRST: rd_byte = {ctl1_q[7], st_q != ST_IDLE, ctl1_q[5:0]};
      ADDR_CTRL_SECOND: rd_byte = ctl2_q;
      ADDR_RESULT_LOW: rd_byte = res_fmt[7:0];
      ADDR_RESULT_HIGH: rd_byte = res_fmt[15:8];
      ADDR_BANDGAP: rd_byte = {7'h00, bg_q[0]};
      ADDR_INT_CTRL: rd_byte = {5'h00, intc_q[2:0]};
      ADDR_SAMPLE: rd_byte = sample_out;
      default: rd_byte = RST_BYTE;
    endcase
    awdone_d = awdone_q || i_awvalid;
    awaddr_d = (i_awvalid && !awdone_q) ? i_awaddr : awaddr_q;
    wdone_d = wdone_q || i_wvalid;
    wdata_d = (i_wvalid && !wdone_q) ? i_wdata : wdata_q;
    wstrb_d = (i_wvalid && !wdone_q) ? i_wstrb : wstrb_q;
    bvalid_d = bvalid_q && !i_bready;
    bresp_err_d = bresp_err_q;
    if (wr_fire)
    begin
      awdone_d = 1'b0;
      wdone_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_err_d = !map_ok(awaddr_q);
    end
    rvalid_d = rvalid_q && !i_rready;
    rdata_d = rdata_q;
    rresp_err_d = rresp_err_q;
    if (rd_fire)
    begin
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, rd_byte};
      rresp_err_d = !rd_ok;
    end
  end

  // ****************************************
  // Registers and sequencer
  // ****************************************
  always_comb
  begin
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    intc_d = intc_q;
    bg_d = bg_q;
    if (wr_fire && wstrb_q[0])
    begin
      unique case (awaddr_q)
        ADDR_CTRL_FIRST: ctl1_d = wdata_q[7:0];
        ADDR_CTRL_SECOND: ctl2_d = wdata_q[7:0];
        ADDR_BANDGAP: bg_d = {7'h00, wdata_q[0]};
        ADDR_INT_CTRL: intc_d = {5'h00, wdata_q[2:0]};
        default: ;
      endcase
    end
    st_d = st_q;
    cyc_d = cyc_q;
    res_d = res_q;
    done_d = 1'b0;
    unique case (st_q)
      ST_IDLE, ST_SAMPLE, ST_CONVERT:
      begin
        if (start_new && !start_q)
        begin
          st_d = ST_ARMED;
          cyc_d = 5'h00;
        end
        else if (st_q != ST_IDLE && div_link.tick)
        begin
          cyc_d = cyc_q + 5'h01;
          if (cyc_q == SAMPLE_CYCLES - 5'h01)
          begin
            st_d = ST_CONVERT;
          end
          if (cyc_q == TOTAL_CYCLES - 5'h01)
          begin
            st_d = ST_IDLE;
            res_d = i_sar_code & FULL_SCALE;
            done_d = 1'b1;
          end
        end
      end
      ST_ARMED:
      begin
        if (!start_new && ctl1_q[F1_PWR])
        begin
          st_d = ST_SAMPLE;
        end
      end
    endcase
    if (!ctl1_d[F1_PWR])
    begin
      st_d = ST_IDLE;
    end
    if (done_d)
    begin
      intc_d[FI_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      st_q <= ST_IDLE;
      ctl1_q <= RST_BYTE;
      ctl2_q <= RST_BYTE;
      intc_q <= RST_BYTE;
      bg_q <= RST_BYTE;
      res_q <= 12'h000;
      cyc_q <= 5'h00;
      start_q <= 1'b0;
      awdone_q <= 1'b0;
      wdone_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_err_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_err_q <= 1'b0;
      rdata_q <= 32'h00000000;
      o_sar_power <= 1'b0;
      o_sar_reset <= 1'b0;
      o_sar_sample <= 1'b0;
      o_sar_ref_supply <= 1'b0;
      o_sar_ext_pin <= 1'b1;
      o_sar_int_source <= 3'h0;
      o_sar_channel <= 4'h0;
      o_bandgap_out <= 1'b0;
      o_bandgap_oe <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      intc_q <= intc_d;
      bg_q <= bg_d;
      res_q <= res_d;
      cyc_q <= cyc_d;
      start_q <= start_new;
      awdone_q <= awdone_d;
      wdone_q <= wdone_d;
      bvalid_q <= bvalid_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_err_q <= bresp_err_d;
      rvalid_q <= rvalid_d;
      rresp_err_q <= rresp_err_d;
      rdata_q <= rdata_d;
      o_sar_power <= ctl1_d[F1_PWR];
      o_sar_reset <= st_d == ST_ARMED;
      o_sar_sample <= st_d == ST_SAMPLE;
      o_sar_ref_supply <= ctl2_d[F2_REF_LSB +: 2] == REF_SUPPLY;
      o_sar_ext_pin <= ctl2_d[F2_SRC_LSB +: 3] == 3'h0 || ctl2_d[F2_SRC_LSB +: 3] > 3'h4;
      o_sar_int_source <= ctl2_d[F2_SRC_LSB +: 3];
      o_sar_channel <= ctl1_d[F1_CHAN_LSB +: 4];
      o_bandgap_out <= bg_d[0];
      o_bandgap_oe <= bg_d[0];
      o_irq <= intc_d[FI_FLAG] && intc_d[FI_GIE] && intc_d[FI_CIE];
    end
  end

  // Bus channels accept at once and never wait on conversion progress.
  assign o_awready = !awdone_q;
  assign o_wready = !wdone_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_err_q ? 2'h2 : 2'h0;
  assign o_arready = !rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_err_q ? 2'h2 : 2'h0;
  wire unused_src = ^src;
endmodule

// ---- tb/adcseq_checker.sv ----
// Checker of the sequencer port behaviour.
`timescale 1ns/1ps
module adcseq_checker
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Bus.
  input wire logic i_awvalid,
  input wire logic i_wvalid,
  input wire logic i_arvalid,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  // Front end.
  input wire logic o_sar_power,
  input wire logic o_sar_reset,
  input wire logic o_sar_sample,
  input wire logic o_sar_ext_pin,
  input wire logic [2:0] o_sar_int_source,
  input wire logic o_bandgap_out,
  input wire logic o_bandgap_oe
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  sequence sample_run;
    o_sar_sample [*4];
  endsequence
  sequence sample_begin;
    $fell(o_sar_reset) && o_sar_power;
  endsequence
  bandgap_link_a: assert property (o_bandgap_oe == o_bandgap_out)
    else $error("bandgap drive and enable differ");
  power_gate_a: assert property (!o_sar_power |=> !o_sar_sample)
    else $error("sampling while unpowered");
  sample_len_a: assert property ($rose(o_sar_sample) |-> sample_run)
    else $error("sampling shorter than four ticks");
  sample_start_a: assert property (sample_begin |-> ##[0:1] o_sar_sample)
    else $error("sampling did not follow start fall");
  sample_clean_a: assert property (o_sar_sample |-> o_sar_power && !o_sar_reset)
    else $error("sampling while armed or unpowered");
  source_route_a: assert property
    (o_sar_ext_pin == (o_sar_int_source == 3'h0 || o_sar_int_source > 3'h4))
    else $error("pin routing does not match source");
  read_upper_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  write_answer_a: assert property
    (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write answer late");
endmodule
bind adcseq_top adcseq_checker adcseq_checker_i (.i_clk_sys, .i_rst_n, .i_awvalid, .i_wvalid,
  .i_arvalid, .o_awready, .o_wready, .o_bvalid, .o_arready, .o_rvalid, .o_rdata, .o_sar_power,
  .o_sar_reset, .o_sar_sample, .o_sar_ext_pin, .o_sar_int_source, .o_bandgap_out, .o_bandgap_oe);

// ---- tb/adcseq_sar_model.sv ----
// Behavioural analog core that answers the sequencer with a held code.
`timescale 1ns/1ps
module adcseq_sar_model
(
  // Clock.
  input wire logic i_clk_sys,
  // Control from the sequencer.
  input wire logic i_power,
  input wire logic i_sample,
  // Analog level and code.
  input wire logic [11:0] i_level,
  output logic [11:0] o_code
);
  initial o_code = 12'hA5A;
  always @(posedge i_clk_sys)
  begin
    if (!i_power)
      o_code <= ~o_code; // Unpowered core gives no stable code.
    else if (i_sample)
      o_code <= i_level; // Twelve-bit code held from sampling on.
  end
endmodule

// ---- tb/adcseq_top_test.sv ----
// Self-checking bench of the converter sequencer.
`timescale 1ns/1ps
module adcseq_top_test;
  import adcseq_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_awaddr = 8'h00;
  logic [7:0] i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h00000000;
  logic i_awvalid = 1'b0;
  logic i_wvalid = 1'b0;
  logic i_arvalid = 1'b0;
  logic [11:0] level = 12'h000;
  logic [11:0] i_sar_code;
  logic [31:0] o_rdata;
  logic [1:0] o_rresp, o_bresp;
  logic [1:0] resp;
  logic [2:0] o_sar_int_source;
  logic [3:0] o_sar_channel;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sar_power, o_sar_reset;
  logic o_sar_sample, o_sar_ref_supply, o_sar_ext_pin, o_bandgap_out, o_bandgap_oe, o_irq;
  integer seed = 32'hFED6C755;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  adcseq_top adcseq_top_i (.i_clk_sys, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready(1'b1), .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready(1'b1), .i_sar_code,
    .o_sar_power, .o_sar_reset, .o_sar_sample, .o_sar_ref_supply, .o_sar_ext_pin,
    .o_sar_int_source, .o_sar_channel, .o_bandgap_out, .o_bandgap_oe, .o_irq);
  adcseq_sar_model adcseq_sar_model_i (.i_clk_sys, .i_power(o_sar_power),
    .i_sample(o_sar_sample), .i_level(level), .o_code(i_sar_code));
  always #12.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) cyc <= cyc + 1;
  task automatic report_and_stop;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        fails++;
        $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    begin
      n = 0;
      i_awaddr <= a;
      i_wdata <= {24'h000000, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      do
      begin
        @(posedge i_clk_sys);
        if (o_awready) i_awvalid <= 1'b0;
        if (o_wready) i_wvalid <= 1'b0;
        n++;
      end while (!o_bvalid && n < 100);
      if (n >= 100) fails++;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    begin
      n = 0;
      i_araddr <= a;
      i_arvalid <= 1'b1;
      do
      begin
        @(posedge i_clk_sys);
        if (o_arready) i_arvalid <= 1'b0;
        n++;
      end while (!o_rvalid && n < 100);
      d = o_rdata;
      resp = o_rresp;
      if (n >= 100) fails++;
    end
  endtask
  function automatic logic [15:0] expect_res(input logic [11:0] r, input logic f);
    expect_res = f ? {4'h0, r} : {r, 4'h0};
  endfunction
  task automatic conv(input logic [2:0] sel, input logic fmt, input logic [1:0] ie);
    logic [2:0] src;
    logic [1:0] rf;
    logic [3:0] ch;
    logic [31:0] d;
    int c0;
    begin
      src = 3'($random(seed));
      rf = 2'($random(seed));
      ch = (src == 3'h0 || src > 3'h4) ? {2'h0, 2'($random(seed))} : 4'hF;
      wr(ADDR_INT_CTRL, {6'h00, ie});
      wr(ADDR_CTRL_SECOND, {3'h0, rf, sel});
      wr(ADDR_CTRL_FIRST, {3'h1, fmt, ch});
      wr(ADDR_CTRL_SECOND, {src, rf, sel});
      chk("irq cleared", o_irq, 1'b0);
      chk("channel", o_sar_channel, ch);
      chk("ref supply", o_sar_ref_supply, rf == REF_SUPPLY);
      chk("ext pin", o_sar_ext_pin, src == 3'h0 || src > 3'h4);
      wr(ADDR_CTRL_FIRST, {3'h5, fmt, ch});
      wr(ADDR_CTRL_FIRST, {3'h1, fmt, ch});
      c0 = cyc;
      rd(ADDR_CTRL_FIRST, d);
      chk("busy", d[F1_BUSY], 1'b1);
      while (d[F1_BUSY] === 1'b1 && cyc - c0 < 9000) rd(ADDR_CTRL_FIRST, d);
      chk("span", cyc - c0 >= (15 << sel) && cyc - c0 <= (17 << sel) + 10, 1'b1);
      rd(ADDR_RESULT_HIGH, d);
      chk("high", d, expect_res(level, fmt) >> 8);
      rd(ADDR_RESULT_LOW, d);
      chk("low", d, expect_res(level, fmt) & 16'h00FF);
      rd(ADDR_INT_CTRL, d);
      chk("flag", d[FI_FLAG], 1'b1);
      chk("irq", o_irq, &ie);
    end
  endtask
  initial
  begin
    #1000000;
    fails++;
    report_and_stop;
  end
  initial
  begin
    logic [31:0] d;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    rd(ADDR_BANDGAP, d);
    chk("bandgap reset", d, 32'h00000000);
    chk("pin reset", o_sar_ext_pin, 1'b1);
    wr(ADDR_BANDGAP, 8'hFF);
    chk("write resp", o_bresp, 2'h0);
    rd(ADDR_BANDGAP, d);
    chk("bandgap read", d, 32'h00000001);
    chk("bandgap on", o_bandgap_oe, 1'b1);
    chk("bandgap level", o_bandgap_out, 1'b1);
    wr(ADDR_BANDGAP, 8'h00);
    rd(ADDR_BANDGAP, d);
    chk("bandgap off", o_bandgap_oe, 1'b0);
    rd(8'h40, d);
    chk("unmapped data", d, 32'h00000000);
    chk("unmapped resp", resp, 2'h2);
    wr(8'h40, 8'h5A);
    chk("unmapped write", o_bresp, 2'h2);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      level <= (i == 0) ? FULL_SCALE : (i == 1) ? 12'h000 : 12'($random(seed));
      conv(3'(i), i[0], i[1:0]);
    end
    $display("test conversions done");
    wr(ADDR_CTRL_SECOND, 8'h02);
    wr(ADDR_CTRL_FIRST, 8'hA0);
    wr(ADDR_CTRL_FIRST, 8'h20);
    repeat (30) @(posedge i_clk_sys);
    wr(ADDR_CTRL_FIRST, 8'h00);
    rd(ADDR_CTRL_FIRST, d);
    chk("abort busy", d[F1_BUSY], 1'b0);
    chk("abort power", o_sar_power, 1'b0);
    $display("test abort done");
    report_and_stop;
  end
endmodule
